// ### logic/hbp_device.sv
module hbp_device
  import hbp_pkg::*;
#(
  parameter int INIT_LEN = hbp_pkg::INIT_TICKS,
  parameter int WAIT_LEN = hbp_pkg::WAIT_TICKS
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Host bus.
  hbp_if.device bus,
  // Channel side.
  input wire logic [3:0] rx_need,
  input wire logic [3:0] tx_need,
  input wire logic [3:0] modem_change,
  input wire logic serial_tx0,
  output logic [3:0] rx_enable,
  output logic [3:0] tx_enable,
  output logic parallel_mode,
  output logic init_done,
  output logic serial_out0
);
  import hbp_pkg::*;
  typedef enum logic [3:0] {
    HBP_INIT = 4'b0001,
    HBP_IDLE = 4'b0010,
    HBP_WORK = 4'b0100,
    HBP_ACK = 4'b1000
  } hbp_state_e;
  hbp_state_e state_ff;
  logic [DATA_W-1:0] regs_ff [NUM_REGS];
  logic tick_ff;
  logic [7:0] count_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic read_ff;
  logic [1:0] kind_ff;
  logic pass_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic drive_ff;
  logic [7:0] sync_in;
  logic cs_n, ds_n, rw, ack_r_n, ack_t_n, ack_m_n, grant_n;
  logic [DATA_W-1:0] data_in;
  logic [ADDR_W-1:0] addr_in;
  logic req_r, req_t, req_m;
  logic ack_any, ack_valid;
  initial begin
    if (INIT_LEN < 1 || INIT_LEN > 255) $error("hbp_device: INIT_LEN out of range");
    if (WAIT_LEN < 1 || WAIT_LEN > 255) $error("hbp_device: WAIT_LEN out of range");
  end
  hbp_sync #(.WIDTH(8)) u_ctl_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({bus.chip_select_n, bus.data_strobe_n, bus.read_not_write,
      bus.rx_service_ack_n, bus.tx_service_ack_n, bus.modem_service_ack_n,
      bus.chain_grant_in_n, 1'b1}),
    .sync_out(sync_in)
  );
  // Address and data are sampled only once strobes have settled through two stages.
  hbp_sync #(.WIDTH(DATA_W + ADDR_W)) u_dat_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({bus.host_data, bus.addr}),
    .sync_out({data_in, addr_in})
  );
  assign {cs_n, ds_n, rw, ack_r_n, ack_t_n, ack_m_n, grant_n} = sync_in[7:1];
  assign req_r = |(rx_need & rx_enable);
  assign req_t = |(tx_need & tx_enable);
  assign req_m = |(modem_change & regs_ff[MODEM_ENABLE_ADDR][3:0]);
  assign ack_any = !ack_r_n || !ack_t_n || !ack_m_n;
  assign ack_valid = (!ack_r_n && req_r) || (!ack_t_n && req_t) || (!ack_m_n && req_m);
  // Divide by two for all internal timing.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) tick_ff <= 1'b0;
    else tick_ff <= ~tick_ff;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= HBP_INIT;
      count_ff <= 8'h00;
      addr_ff <= '0;
      read_ff <= 1'b0;
      kind_ff <= 2'd0;
      pass_ff <= 1'b1;
    end else begin
      case (state_ff)
        HBP_INIT: begin
          if (tick_ff) count_ff <= count_ff + 8'h01;
          if (tick_ff && count_ff == 8'(INIT_LEN - 1)) state_ff <= HBP_IDLE;
        end
        HBP_IDLE: begin
          count_ff <= 8'h00;
          pass_ff <= 1'b1;
          if (!grant_n && !ds_n && ack_valid) begin
            kind_ff <= !ack_r_n ? 2'd1 : (!ack_t_n ? 2'd2 : 2'd3);
            read_ff <= 1'b1;
            state_ff <= HBP_WORK;
          end else if (!grant_n && !ds_n && ack_any) begin
            pass_ff <= 1'b0;
          end else if (!cs_n && !ds_n) begin
            addr_ff <= addr_in;
            read_ff <= rw;
            kind_ff <= 2'd0;
            state_ff <= HBP_WORK;
          end
        end
        HBP_WORK: begin
          if (tick_ff) count_ff <= count_ff + 8'h01;
          if (tick_ff && count_ff == 8'(WAIT_LEN - 1)) state_ff <= HBP_ACK;
        end
        HBP_ACK: begin
          if (ds_n) state_ff <= HBP_IDLE;
        end
        default: state_ff <= HBP_INIT;
      endcase
    end
  end
  // Register file; revision lands when initialization finishes.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) regs_ff[i] <= REG_RESET;
    end else if (state_ff == HBP_INIT && tick_ff && count_ff == 8'(INIT_LEN - 1)) begin
      regs_ff[REVISION_ADDR] <= FW_REVISION;
    end else if (state_ff == HBP_WORK && !read_ff && kind_ff == 2'd0 && tick_ff
                 && count_ff == 8'(WAIT_LEN - 1) && addr_ff != REVISION_ADDR) begin
      regs_ff[addr_ff] <= data_in;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= REG_RESET;
      drive_ff <= 1'b0;
    end else begin
      case (kind_ff)
        2'd1: rdata_ff <= regs_ff[RX_VECTOR_ADDR];
        2'd2: rdata_ff <= regs_ff[TX_VECTOR_ADDR];
        2'd3: rdata_ff <= regs_ff[MODEM_VECTOR_ADDR];
        default: rdata_ff <= regs_ff[addr_ff];
      endcase
      drive_ff <= read_ff && (state_ff == HBP_WORK || state_ff == HBP_ACK) && !ds_n;
    end
  end
  assign bus.dev_data_out = rdata_ff;
  assign bus.dev_data_oe = drive_ff;
  assign bus.transfer_ack_n_out = 1'b0;
  assign bus.transfer_ack_oe = (state_ff == HBP_ACK);
  assign bus.rx_service_req_n = ~req_r;
  assign bus.tx_service_req_n = ~req_t;
  assign bus.modem_service_req_n = ~req_m;
  assign bus.chain_pass_out_n = pass_ff;
  assign rx_enable = regs_ff[CHAN_ENABLE_ADDR][3:0];
  assign tx_enable = regs_ff[CHAN_ENABLE_ADDR][7:4];
  assign parallel_mode = regs_ff[PAR_MODE_ADDR][0];
  assign init_done = (state_ff != HBP_INIT);
  // Printer strobe is driven on the serial output from mode register bit 1 when in parallel mode.
  assign serial_out0 = parallel_mode ? regs_ff[PAR_MODE_ADDR][1] : serial_tx0;
endmodule // hbp_device

// ### logic/hbp_host.sv
module hbp_host
  import hbp_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Host bus.
  hbp_if.host bus,
  // User request side.
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic [1:0] req_kind,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic rsp_passed,
  output logic [2:0] service_req
);
  import hbp_pkg::*;
  typedef enum logic [2:0] {
    HBH_IDLE = 3'b001,
    HBH_WAIT = 3'b010,
    HBH_END = 3'b100
  } hbh_state_e;
  hbh_state_e state_ff;
  logic [2:0] ctl_ff;
  logic read_ff;
  logic [1:0] kind_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff, rsp_data_ff;
  logic rsp_valid_ff, rsp_passed_ff;
  logic [9:0] sync_in;
  logic [DATA_W-1:0] data_in;
  logic ack_n, pass_n;
  hbp_sync #(.WIDTH(10)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({bus.transfer_ack_n, bus.chain_pass_out_n, bus.host_data}),
    .sync_out(sync_in)
  );
  assign {ack_n, pass_n, data_in} = sync_in;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= HBH_IDLE;
      read_ff <= 1'b1;
      kind_ff <= 2'd0;
      addr_ff <= '0;
      wdata_ff <= REG_RESET;
      rsp_data_ff <= REG_RESET;
      rsp_valid_ff <= 1'b0;
      rsp_passed_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= 1'b0;
      case (state_ff)
        HBH_IDLE: if (req_valid) begin
          read_ff <= req_read || req_kind != 2'd0;
          kind_ff <= req_kind;
          addr_ff <= req_addr;
          wdata_ff <= req_wdata;
          state_ff <= HBH_WAIT;
        end
        HBH_WAIT: begin
          if (!ack_n) begin
            rsp_data_ff <= data_in;
            rsp_passed_ff <= 1'b0;
            state_ff <= HBH_END;
          end else if (kind_ff != 2'd0 && !pass_n) begin
            rsp_passed_ff <= 1'b1;
            state_ff <= HBH_END;
          end
        end
        // A late pass level would end the next service cycle at once, so wait for both.
        HBH_END: if (ack_n && pass_n) begin
          rsp_valid_ff <= 1'b1;
          state_ff <= HBH_IDLE;
        end
        default: state_ff <= HBH_IDLE;
      endcase
    end
  end
  assign ctl_ff = {kind_ff == 2'd1, kind_ff == 2'd2, kind_ff == 2'd3};
  assign req_ready = (state_ff == HBH_IDLE);
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign rsp_passed = rsp_passed_ff;
  assign service_req = ~{bus.rx_service_req_n, bus.tx_service_req_n, bus.modem_service_req_n};
  assign bus.chip_select_n = !(state_ff == HBH_WAIT && kind_ff == 2'd0);
  assign bus.data_strobe_n = (state_ff != HBH_WAIT);
  assign bus.read_not_write = read_ff;
  assign bus.addr = addr_ff;
  assign bus.host_data_out = wdata_ff;
  assign bus.host_data_oe = (state_ff != HBH_IDLE) && !read_ff;
  assign bus.rx_service_ack_n = !(state_ff == HBH_WAIT && ctl_ff[2]);
  assign bus.tx_service_ack_n = !(state_ff == HBH_WAIT && ctl_ff[1]);
  assign bus.modem_service_ack_n = !(state_ff == HBH_WAIT && ctl_ff[0]);
  assign bus.chain_grant_in_n = !(state_ff == HBH_WAIT && kind_ff != 2'd0);
endmodule // hbp_host

// ### logic/hbp_if.sv
interface hbp_if;
  logic chip_select_n;
  logic data_strobe_n;
  logic read_not_write;
  logic [hbp_pkg::ADDR_W-1:0] addr;
  logic [hbp_pkg::DATA_W-1:0] host_data_out;
  logic host_data_oe;
  logic [hbp_pkg::DATA_W-1:0] dev_data_out;
  logic dev_data_oe;
  logic transfer_ack_n_out;
  logic transfer_ack_oe;
  logic rx_service_req_n;
  logic tx_service_req_n;
  logic modem_service_req_n;
  logic rx_service_ack_n;
  logic tx_service_ack_n;
  logic modem_service_ack_n;
  logic chain_grant_in_n;
  logic chain_pass_out_n;
  logic [hbp_pkg::DATA_W-1:0] host_data;
  logic transfer_ack_n;
  assign host_data = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : '1);
  assign transfer_ack_n = transfer_ack_oe ? transfer_ack_n_out : 1'b1;
  modport device (
    input chip_select_n, data_strobe_n, read_not_write, addr, host_data,
    input rx_service_ack_n, tx_service_ack_n, modem_service_ack_n, chain_grant_in_n,
    output dev_data_out, dev_data_oe, transfer_ack_n_out, transfer_ack_oe,
    output rx_service_req_n, tx_service_req_n, modem_service_req_n, chain_pass_out_n
  );
  modport host (
    output chip_select_n, data_strobe_n, read_not_write, addr, host_data_out, host_data_oe,
    output rx_service_ack_n, tx_service_ack_n, modem_service_ack_n, chain_grant_in_n,
    input host_data, transfer_ack_n, rx_service_req_n, tx_service_req_n, modem_service_req_n,
    input chain_pass_out_n
  );
endinterface

// ### logic/hbp_pkg.sv
// Function
// - Host holds reset low ten clocks
// - After reset, transmitters and receivers disabled
// - Revision written when initialization completes
// - Internal timing runs at clock divided by two
// - Cycle starts on select and strobe together
// - Writes latch on strobe, reads drive data
// - Direction high reads, low writes
// - Transfer acknowledge after internal work completes
// - Host ends cycle only after acknowledge; the host also ends a service cycle when pass goes low
// - Seven-bit address picks the register
// - Eight-bit data bus, driven on reads only
// - Receive request while any receiver needs service; the code requests only for receivers enabled in the channel enable register
// - Transmit request while any transmitter needs service; the code requests only for transmitters enabled in the channel enable register
// - Modem request on enabled modem change
// - Receive acknowledge reads receive vector
// - Transmit acknowledge reads transmit vector
// - Modem acknowledge reads modem vector
// - Acknowledge needs grant, strobe, valid acknowledge
// - No pending request: drive pass low
// - Parallel channel 0 reuses serial out as strobe
package hbp_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 128;
  localparam int RESET_MIN_CLOCKS = 10;
  localparam int INIT_TICKS = 8;
  localparam int WAIT_TICKS = 2;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] FW_REVISION = 8'h5a; // Arbitrary value.
  localparam logic [ADDR_W-1:0] REVISION_ADDR = 7'h40;
  localparam logic [ADDR_W-1:0] RX_VECTOR_ADDR = 7'h41;
  localparam logic [ADDR_W-1:0] TX_VECTOR_ADDR = 7'h42;
  localparam logic [ADDR_W-1:0] MODEM_VECTOR_ADDR = 7'h43;
  localparam logic [ADDR_W-1:0] CHAN_ENABLE_ADDR = 7'h44;
  localparam logic [ADDR_W-1:0] PAR_MODE_ADDR = 7'h45;
  localparam logic [ADDR_W-1:0] MODEM_ENABLE_ADDR = 7'h46;
  localparam int HOST_DIV = 4;
endpackage

// ### logic/hbp_sync.sv
module hbp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  initial begin
    if (WIDTH < 1) $error("hbp_sync: WIDTH must be at least 1");
  end
  // Inactive level of all handled inputs is high.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= '1;
      stage2_ff <= '1;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end
  assign sync_out = stage2_ff;
endmodule // hbp_sync

// ### tb/hbp_props.sv
module hbp_props (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Host side of the bus.
  input wire logic chip_select_n,
  input wire logic data_strobe_n,
  input wire logic read_not_write,
  input wire logic rx_service_ack_n,
  input wire logic tx_service_ack_n,
  input wire logic modem_service_ack_n,
  input wire logic chain_grant_in_n,
  // Device side of the bus.
  input wire logic dev_data_oe,
  input wire logic transfer_ack_n_out,
  input wire logic transfer_ack_oe,
  input wire logic transfer_ack_n,
  input wire logic chain_pass_out_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic any_ack;
  assign any_ack = !(rx_service_ack_n && tx_service_ack_n && modem_service_ack_n);
  chk_ack_open_drain: assert property (transfer_ack_oe |-> !transfer_ack_n_out)
    else $error("acknowledge driven high");
  chk_ack_on_strobe: assert property ($fell(transfer_ack_n) |-> !data_strobe_n)
    else $error("acknowledge without strobe");
  chk_ack_cycle_start: assert property ($fell(transfer_ack_n) |->
    !chip_select_n || (!chain_grant_in_n && any_ack)) else $error("acknowledge without a cycle");
  chk_pass_no_ack: assert property (!chain_pass_out_n |-> transfer_ack_n)
    else $error("pass and acknowledge together");
  chk_pass_on_svc: assert property ($fell(chain_pass_out_n) |-> !data_strobe_n && any_ack)
    else $error("pass without service acknowledge");
  chk_ack_in_time: assert property ($fell(data_strobe_n) && !chip_select_n |->
    ##[2:30] !transfer_ack_n) else $error("register cycle never acknowledged");
  chk_ack_release: assert property ($rose(data_strobe_n) |-> ##[1:6] transfer_ack_n)
    else $error("acknowledge held after strobe");
  chk_read_drives: assert property ($fell(transfer_ack_n) && read_not_write &&
    !chip_select_n |-> dev_data_oe) else $error("read without data");
  chk_write_quiet: assert property (!chip_select_n && !read_not_write &&
    !transfer_ack_n |-> !dev_data_oe) else $error("data driven on write");
  chk_svc_data: assert property ($fell(transfer_ack_n) && any_ack |-> dev_data_oe)
    else $error("service cycle without vector");
  cover property ($fell(transfer_ack_n) && any_ack);
  cover property ($fell(chain_pass_out_n));
  cover property ($fell(transfer_ack_n) && !read_not_write && !chip_select_n);
endmodule // hbp_props

// ### tb/hbp_tb_top.sv
module hbp_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import hbp_pkg::*;
  localparam logic [6:0] REG_LIST [4] = '{RX_VECTOR_ADDR, TX_VECTOR_ADDR,
    MODEM_VECTOR_ADDR, CHAN_ENABLE_ADDR};
  logic clock, rst_n, req_valid, req_read, req_ready, rsp_valid, rsp_passed;
  logic [1:0] req_kind;
  logic [6:0] req_addr;
  logic [7:0] req_wdata, rsp_data;
  logic [2:0] service_req;
  logic [3:0] rx_need, tx_need, modem_change, rx_enable, tx_enable;
  logic serial_tx0, parallel_mode, init_done, serial_out0;
  int errors = 0;
  int check_count = 0;
  hbp_if hbp_if_inst ();
  hbp_device #(.INIT_LEN(4), .WAIT_LEN(1)) hbp_device_inst (.clock(clock), .rst_n(rst_n),
    .bus(hbp_if_inst), .rx_need(rx_need), .tx_need(tx_need), .modem_change(modem_change),
    .serial_tx0(serial_tx0), .rx_enable(rx_enable), .tx_enable(tx_enable),
    .parallel_mode(parallel_mode), .init_done(init_done), .serial_out0(serial_out0));
  hbp_host hbp_host_inst (.clock(clock), .rst_n(rst_n), .bus(hbp_if_inst),
    .req_valid(req_valid), .req_read(req_read), .req_kind(req_kind), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_passed(rsp_passed), .service_req(service_req));
  hbp_props hbp_props_inst (.clock(clock), .rst_n(rst_n),
    .chip_select_n(hbp_if_inst.chip_select_n), .data_strobe_n(hbp_if_inst.data_strobe_n),
    .read_not_write(hbp_if_inst.read_not_write),
    .rx_service_ack_n(hbp_if_inst.rx_service_ack_n),
    .tx_service_ack_n(hbp_if_inst.tx_service_ack_n),
    .modem_service_ack_n(hbp_if_inst.modem_service_ack_n),
    .chain_grant_in_n(hbp_if_inst.chain_grant_in_n), .dev_data_oe(hbp_if_inst.dev_data_oe),
    .transfer_ack_n_out(hbp_if_inst.transfer_ack_n_out),
    .transfer_ack_oe(hbp_if_inst.transfer_ack_oe),
    .transfer_ack_n(hbp_if_inst.transfer_ack_n),
    .chain_pass_out_n(hbp_if_inst.chain_pass_out_n));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One request through the host end; waits for its response pulse.
  task automatic access(input logic rd, input logic [1:0] kind, input logic [6:0] a,
    input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_read <= rd;
    req_kind <= kind;
    req_addr <= a;
    req_wdata <= wd;
    @(negedge clock);
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    check({7'h0, rsp_valid}, 8'h01);
  endtask

  task automatic t_reset();
    int n;
    n = 0;
    @(negedge clock);
    check({tx_enable, rx_enable}, 8'h00);
    check({6'h0, hbp_if_inst.transfer_ack_n, hbp_if_inst.chain_pass_out_n}, 8'h03);
    while (init_done !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    check({7'h0, n > 4}, 8'h01);
    access(1'b1, 2'd0, REVISION_ADDR, 8'h00);
    check(rsp_data, FW_REVISION);
  endtask

  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      access(1'b0, 2'd0, REG_LIST[i], {1'b1, REG_LIST[i]});
      access(1'b1, 2'd0, REG_LIST[i], 8'h00);
      check(rsp_data, {1'b1, REG_LIST[i]});
    end
    check({tx_enable, rx_enable}, 8'hc4);
    access(1'b0, 2'd0, REVISION_ADDR, 8'h00);
    access(1'b1, 2'd0, REVISION_ADDR, 8'h00);
    check(rsp_data, FW_REVISION);
  endtask

  task automatic t_service();
    @(posedge clock);
    modem_change <= 4'h2;
    repeat (6) @(negedge clock);
    check({7'h0, hbp_if_inst.modem_service_req_n}, 8'h01);
    @(posedge clock);
    modem_change <= 4'h0;
    access(1'b0, 2'd0, MODEM_ENABLE_ADDR, 8'h0f);
    for (int k = 1; k < 4; k++) begin
      access(1'b1, 2'(k), 7'h00, 8'h00);
      check({7'h0, rsp_passed}, 8'h01);
      @(posedge clock);
      rx_need <= (k == 1) ? 4'h4 : 4'h0;
      tx_need <= (k == 2) ? 4'h4 : 4'h0;
      modem_change <= (k == 3) ? 4'h2 : 4'h0;
      repeat (6) @(negedge clock);
      check({5'h0, service_req}, 8'h01 << (3 - k));
      check({5'h0, hbp_if_inst.rx_service_req_n, hbp_if_inst.tx_service_req_n,
        hbp_if_inst.modem_service_req_n}, ~(8'h01 << (3 - k)) & 8'h07);
      access(1'b1, 2'(k), 7'h00, 8'h00);
      check({7'h0, rsp_passed}, 8'h00);
      check(rsp_data, {1'b1, REG_LIST[k - 1]});
      @(posedge clock);
      rx_need <= 4'h0;
      tx_need <= 4'h0;
      modem_change <= 4'h0;
    end
  endtask

  task automatic t_printer();
    @(posedge clock);
    serial_tx0 <= 1'b1;
    repeat (3) @(negedge clock);
    check({6'h0, parallel_mode, serial_out0}, 8'h01);
    access(1'b0, 2'd0, PAR_MODE_ADDR, 8'h01);
    check({6'h0, parallel_mode, serial_out0}, 8'h02);
    access(1'b0, 2'd0, PAR_MODE_ADDR, 8'h03);
    check({6'h0, parallel_mode, serial_out0}, 8'h03);
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_read = 1'b0;
    req_kind = 2'd0;
    req_addr = 7'h00;
    req_wdata = 8'h00;
    rx_need = 4'h0;
    tx_need = 4'h0;
    modem_change = 4'h0;
    serial_tx0 = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_service();
    t_printer();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    end_of_test();
  end
endmodule // hbp_tb_top
